// ---- src/fmss_pkg.sv ----
// Purpose: shared constants and types of the field master setup block
// Assumes: apb byte address is four times the shared buffer word index
// Notes:   station words sit at indices 0x20..0x5f, one per station
package fmss_pkg;
	// shared buffer word indices
	localparam logic [6:0] IDX_CFG       = 7'h18;
	localparam logic [6:0] IDX_IRQ_ST    = 7'h19;
	localparam logic [6:0] IDX_IRQ_MSK   = 7'h1a;
	localparam logic [6:0] IDX_LINK_ST   = 7'h1c;
	localparam logic [6:0] IDX_CMD       = 7'h1d;
	localparam logic [6:0] IDX_FLT_LO    = 7'h1e;
	localparam logic [6:0] IDX_FLT_HI    = 7'h1f;
	localparam logic [6:0] IDX_STN_FIRST = 7'h20;
	localparam logic [6:0] IDX_STN_LAST  = 7'h5f;
	localparam int         N_STN         = 64;

	// station information word fields
	localparam int B_NPTS_HI = 4;
	localparam int B_IN      = 8;
	localparam int B_OUT     = 9;
	localparam int B_HEAD    = 11;
	localparam int B_RSV     = 15;

	// link status word and command word bits
	localparam int B_DONE    = 4;
	localparam int B_RERUN   = 0;

	// interrupt bits
	localparam int IRQ_W     = 3;
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_FLT   = 1;
	localparam int IRQ_RATE  = 2;
	localparam logic [2:0] IRQ_MSK_RST = 3'h0;

	// switch positions (switch n is bit n-1)
	localparam int SW_RATE0  = 0;
	localparam int SW_RATE1  = 1;
	localparam int SW_PT     = 2;
	localparam int SW_UNUSED0 = 3;
	localparam int SW_UNUSED1 = 4;
	localparam int SW_OP0    = 5;
	localparam int SW_OP1    = 6;
	localparam int SW_UNUSED2 = 7;

	// switch settle time before the one-time sample
	localparam int CLK_NS     = 10;
	localparam int SETTLE_NS  = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		RATE_156K = 2'h0,
		RATE_625K = 2'h1,
		RATE_2M5  = 2'h2,
		RATE_BAD  = 2'h3
	} fmss_rate_t;

	typedef enum logic [2:0] {
		ST_SETTLE  = 3'h1,
		ST_RUN     = 3'h2,
		ST_COLLECT = 3'h4
	} fmss_state_t;
endpackage : fmss_pkg

// ---- src/fmss_stn_check.sv ----
// Purpose: per-station fault and activity decision
// Assumes: present comes from link logic on the same clock
// Notes:   reserved stations still exchange data but raise no fault
`timescale 1ns/10ps
module fmss_stn_check (
	// station information word
	input  wire logic [15:0] info,
	// link state
	input  wire logic        present,
	input  wire logic        online,
	// decision
	output logic             fault,
	output logic             active
);
	logic configured;

	// a word with points or direction flags names a configured station
	always_comb begin
		configured = (|info[fmss_pkg::B_NPTS_HI:0]) | info[fmss_pkg::B_IN]
		             | info[fmss_pkg::B_OUT];
		active = configured;
		fault  = online & configured & ~info[fmss_pkg::B_RSV] & ~present;
	end
endmodule : fmss_stn_check

// ---- src/fmss_sync2.sv ----
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels such as switches
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module fmss_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// levels
	input  wire logic [W-1:0] d_async,
	output logic      [W-1:0] q_sync
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_nxt;

	// next values are the pin and the first stage
	always_comb begin
		meta_nxt = d_async;
		sync_nxt = meta_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q_sync <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_sync <= sync_nxt;
		end
	end
endmodule : fmss_sync2

// ---- src/fmss_top.sv ----
// Purpose: switch decode, station information words and supervision
// Assumes: apb slave, zero wait states, registered read data
// Notes:   switches are read once after reset; changes need a new reset
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
// Operation
// - reserved station that is present still exchanges data, no fault reported
// - rerun of auto assignment rewrites all station words, clearing reserved flags
// - configured, unreserved, absent station reports a wire-break fault; the code flags it only in online mode in ST_RUN
// - composite module word has input and output bits both set
// - head-station bit set only in first unit of a multi-unit module
// - rate switches: off/off 156k, on/off 625k, off/on 2.5M; on/on forbidden
// - point switch on selects 16-point, off selects 4-point mode
// - operation switches: off/off online, on/off auto-assign, off/on test
// - end of collection sets bit 4 of word 28
// - bit 15 of each station word is the reserved flag
// - station words occupy word 32 (station 1) to word 95 (station 64)
module fmss_top (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// setting switches (pins)
	input  wire logic [7:0]  sw_pin,
	// link scanner
	input  wire logic [63:0] stn_present,
	input  wire logic        disc_valid,
	input  wire logic [5:0]  disc_stn,
	input  wire logic [4:0]  disc_npts,
	input  wire logic        disc_in,
	input  wire logic        disc_out,
	input  wire logic        disc_first,
	input  wire logic        disc_end,
	output logic             assign_run,
	// decoded configuration
	output logic [1:0]       rate_code,
	output logic             point_mode_select,
	output logic             mode_online,
	output logic             mode_assign,
	output logic             mode_test,
	output logic [63:0]      stn_active,
	// interrupt
	output logic             irq
);
	logic [7:0]              sw_s;
	logic [63:0]             flt_vec;
	fmss_pkg::fmss_state_t   st_r, st_nxt;
	logic [7:0]              cnt_r, cnt_nxt;
	logic [7:0]              sw_r, sw_nxt;
	logic [15:0]             mem_r [64];
	logic [15:0]             mem_nxt [64];
	logic                    done_r, done_nxt;
	logic [63:0]             flt_r;
	logic [2:0]              ist_r, ist_nxt;
	logic [2:0]              imsk_r, imsk_nxt;
	logic [31:0]             rd_r, rd_nxt;
	logic [6:0]              idx;
	logic                    wr_acc, rd_set, mapped, is_stn;
	logic                    start_col, rate_bad;
	logic [5:0]              sidx;

	// switch pins cross into the clock domain first
	fmss_sync2 #(.W(8)) u_sw_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d_async (sw_pin),
		.q_sync  (sw_s)
	);

	// one checker per station word
	genvar gi;
	generate
		for (gi = 0; gi < fmss_pkg::N_STN; gi++) begin : g_stn
			fmss_stn_check u_chk (
				.info    (mem_r[gi]),
				.present (stn_present[gi]),
				.online  (mode_online & (st_r == fmss_pkg::ST_RUN)),
				.fault   (flt_vec[gi]),
				.active  (stn_active[gi])
			);
		end
	endgenerate

	// apb decode, byte address is four times the word index
	always_comb begin
		idx    = paddr[8:2];
		is_stn = (idx >= fmss_pkg::IDX_STN_FIRST) && (idx <= fmss_pkg::IDX_STN_LAST);
		sidx   = idx[5:0] - fmss_pkg::IDX_STN_FIRST[5:0];
		mapped = is_stn && (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
		case (idx)
			fmss_pkg::IDX_CFG, fmss_pkg::IDX_IRQ_ST, fmss_pkg::IDX_IRQ_MSK,
			fmss_pkg::IDX_LINK_ST, fmss_pkg::IDX_CMD, fmss_pkg::IDX_FLT_LO,
			fmss_pkg::IDX_FLT_HI: begin
				mapped = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
			end
			default: begin
			end
		endcase
		wr_acc  = psel & penable & pwrite & mapped;
		rd_set  = psel & ~penable & ~pwrite;
		pready  = 1'b1;
		pslverr = psel & penable & ~mapped;
	end

	// decode of the sampled switches
	always_comb begin
		rate_code = {sw_r[fmss_pkg::SW_RATE1], sw_r[fmss_pkg::SW_RATE0]};
		rate_bad  = (rate_code == fmss_pkg::RATE_BAD);
		point_mode_select = sw_r[fmss_pkg::SW_PT];
		mode_online = ~sw_r[fmss_pkg::SW_OP0] & ~sw_r[fmss_pkg::SW_OP1];
		mode_assign =  sw_r[fmss_pkg::SW_OP0] & ~sw_r[fmss_pkg::SW_OP1];
		mode_test   = ~sw_r[fmss_pkg::SW_OP0] &  sw_r[fmss_pkg::SW_OP1];
		assign_run  = (st_r == fmss_pkg::ST_COLLECT);
	end

	// sequencer: settle, sample switches once, then run or collect
	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		sw_nxt    = sw_r;
		start_col = 1'b0;
		case (st_r)
			fmss_pkg::ST_SETTLE: begin
				cnt_nxt = cnt_r + 8'h01;
				if (cnt_r == 8'(fmss_pkg::SETTLE_CYC - 1)) begin
					sw_nxt = sw_s;
					st_nxt = fmss_pkg::ST_RUN;
					// assignment starts by itself when powered up in that mode
					if (sw_s[fmss_pkg::SW_OP0] & ~sw_s[fmss_pkg::SW_OP1]) begin
						st_nxt    = fmss_pkg::ST_COLLECT;
						start_col = 1'b1;
					end
				end
			end
			fmss_pkg::ST_RUN: begin
				// software rerun only honoured in auto-assign mode
				if (wr_acc && idx == fmss_pkg::IDX_CMD && pwdata[fmss_pkg::B_RERUN]
				    && mode_assign) begin
					st_nxt    = fmss_pkg::ST_COLLECT;
					start_col = 1'b1;
				end
			end
			fmss_pkg::ST_COLLECT: begin
				if (disc_end) begin
					st_nxt = fmss_pkg::ST_RUN;
				end
			end
			default: begin
				st_nxt = fmss_pkg::ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r  <= fmss_pkg::ST_SETTLE;
			cnt_r <= 8'h00;
			sw_r  <= 8'h00;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
			sw_r  <= sw_nxt;
		end
	end

	// station words: software writes, cleared and refilled by collection
	always_comb begin
		for (int i = 0; i < fmss_pkg::N_STN; i++) begin
			mem_nxt[i] = start_col ? 16'h0000 : mem_r[i];
		end
		if (wr_acc && is_stn) begin
			mem_nxt[sidx] = pwdata[15:0];
		end
		// discovered unit overrides a write in the same cycle
		if (assign_run && disc_valid) begin
			mem_nxt[disc_stn] = 16'h0000;
			mem_nxt[disc_stn][fmss_pkg::B_NPTS_HI:0] = disc_npts;
			mem_nxt[disc_stn][fmss_pkg::B_IN]   = disc_in;
			mem_nxt[disc_stn][fmss_pkg::B_OUT]  = disc_out;
			mem_nxt[disc_stn][fmss_pkg::B_HEAD] = disc_first;
			mem_nxt[disc_stn][fmss_pkg::B_RSV]  = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < fmss_pkg::N_STN; i++) begin
				mem_r[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < fmss_pkg::N_STN; i++) begin
				mem_r[i] <= mem_nxt[i];
			end
		end
	end

	// completion flag, faults and interrupt status
	always_comb begin
		done_nxt = done_r;
		if (start_col) begin
			done_nxt = 1'b0;
		end
		if (assign_run && disc_end) begin
			done_nxt = 1'b1;
		end
		imsk_nxt = imsk_r;
		ist_nxt  = ist_r;
		if (wr_acc && idx == fmss_pkg::IDX_IRQ_MSK) begin
			imsk_nxt = pwdata[2:0];
		end
		if (wr_acc && idx == fmss_pkg::IDX_IRQ_ST) begin
			ist_nxt = ist_r & ~pwdata[2:0];
		end
		// set after clear so a same-cycle event is never lost
		if (assign_run && disc_end) begin
			ist_nxt[fmss_pkg::IRQ_DONE] = 1'b1;
		end
		if (|(flt_vec & ~flt_r)) begin
			ist_nxt[fmss_pkg::IRQ_FLT] = 1'b1;
		end
		if (rate_bad && st_r == fmss_pkg::ST_RUN) begin
			ist_nxt[fmss_pkg::IRQ_RATE] = 1'b1;
		end
		irq = |(ist_r & imsk_r);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
			flt_r  <= 64'h0;
			ist_r  <= 3'h0;
			imsk_r <= fmss_pkg::IRQ_MSK_RST;
		end else begin
			done_r <= done_nxt;
			flt_r  <= flt_vec;
			ist_r  <= ist_nxt;
			imsk_r <= imsk_nxt;
		end
	end

	// read data captured in the setup phase, held through access
	always_comb begin
		rd_nxt = rd_r;
		if (rd_set) begin
			rd_nxt = 32'h0;
			// refused addresses fall to the default and read zero
			if (mapped && is_stn) begin
				rd_nxt[15:0] = mem_r[sidx];
			end
			case (mapped ? idx : 7'h00)
				fmss_pkg::IDX_CFG: begin
					// unused switches shown so a misset is visible
					rd_nxt[7:0] = sw_r;
					rd_nxt[8]   = (st_r != fmss_pkg::ST_SETTLE);
				end
				fmss_pkg::IDX_IRQ_ST:  rd_nxt[2:0] = ist_r;
				fmss_pkg::IDX_IRQ_MSK: rd_nxt[2:0] = imsk_r;
				fmss_pkg::IDX_LINK_ST: rd_nxt[fmss_pkg::B_DONE] = done_r;
				fmss_pkg::IDX_CMD:     rd_nxt[fmss_pkg::B_RERUN] = assign_run;
				fmss_pkg::IDX_FLT_LO:  rd_nxt = flt_r[31:0];
				fmss_pkg::IDX_FLT_HI:  rd_nxt = flt_r[63:32];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_r <= 32'h0;
		end else begin
			rd_r <= rd_nxt;
		end
	end

	assign prdata = rd_r;
endmodule : fmss_top

// ---- tb/fmss_stations.sv ----
// Purpose: remote station line-up answering a collection run
// Assumes: four stations, a composite module spanning stations 2 and 3
// Notes:   unit fields change every cycle while collection runs and no unit is offered
`timescale 1ns/10ps
module fmss_stations (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// master side
	input  wire logic        assign_run,
	input  wire logic [63:0] drop,
	output logic      [63:0] stn_present,
	output logic             disc_valid,
	output logic      [5:0]  disc_stn,
	output logic      [4:0]  disc_npts,
	output logic             disc_in,
	output logic             disc_out,
	output logic             disc_first,
	output logic             disc_end
);
	logic [3:0]  k_r;
	logic [13:0] u;
	// unit table: station, points, in, out, first
	always_comb begin
		case (k_r)
			4'h2: u = {6'h00, 5'h04, 3'b101};
			4'h3: u = {6'h01, 5'h02, 3'b111};
			4'h4: u = {6'h02, 5'h02, 3'b110};
			4'h5: u = {6'h03, 5'h04, 3'b011};
			default: u = {k_r, k_r, k_r, k_r[1:0]};
		endcase
	end
	assign {disc_stn, disc_npts, disc_in, disc_out, disc_first} = u;
	assign disc_valid = assign_run && k_r >= 4'h2 && k_r <= 4'h5;
	assign disc_end = assign_run && k_r == 4'h7;
	assign stn_present = 64'hf & ~drop;
	// step through the table only while collection runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) k_r <= 4'h0;
		else if (!assign_run) k_r <= 4'h0;
		else if (k_r != 4'hf) k_r <= k_r + 4'h1;
	end
endmodule : fmss_stations

// ---- tb/fmss_top_sva.sv ----
// Purpose: port-level checks of switch decode and station collection
// Assumes: switches are held steady from reset until well after sampling
// Notes:   settle counter stands in for the design's hidden sample time
`timescale 1ns/10ps
module fmss_top_sva (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pslverr,
	// switches and collection
	input wire logic [7:0]  sw_pin,
	input wire logic        disc_valid,
	input wire logic [5:0]  disc_stn,
	input wire logic        disc_in,
	input wire logic        disc_out,
	input wire logic        disc_end,
	input wire logic        assign_run,
	// decoded outputs
	input wire logic [1:0]  rate_code,
	input wire logic        point_mode_select,
	input wire logic        mode_online,
	input wire logic        mode_assign,
	input wire logic        mode_test,
	input wire logic [63:0] stn_active
);
	logic [6:0] cnt_r, cnt_nxt;
	logic [7:0] cap_r, cap_nxt;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// cycles since release, saturating; switches captured mid-settle
	always_comb begin
		cnt_nxt = (cnt_r == 7'h7f) ? cnt_r : cnt_r + 7'h01;
		cap_nxt = (cnt_r == 7'h32) ? sw_pin : cap_r;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 7'h00;
			cap_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
			cap_r <= cap_nxt;
		end
	end
	a_rate_sampled: assert property (cnt_r == 7'h73 |-> rate_code == cap_r[1:0])
		else $error("rate decode wrong");
	a_point_sampled: assert property (cnt_r == 7'h73 |-> point_mode_select == cap_r[2])
		else $error("point mode decode wrong");
	a_mode_sampled: assert property (cnt_r == 7'h73 |->
		mode_assign == (cap_r[5] & ~cap_r[6]) && mode_test == (cap_r[6] & ~cap_r[5]))
		else $error("operation mode decode wrong");
	a_mode_exclusive: assert property (mode_online == !(mode_assign || mode_test)
		&& !(mode_assign && mode_test)) else $error("modes not exclusive");
	a_setting_held: assert property (cnt_r == 7'h7f |=> $stable(rate_code)
		&& $stable(point_mode_select) && $stable(mode_assign)) else $error("setting moved");
	a_start_clears: assert property ($rose(assign_run) |-> stn_active == 64'h0)
		else $error("words not cleared at start");
	a_unit_lands: assert property (assign_run && disc_valid && (disc_in || disc_out)
		|=> stn_active[$past(disc_stn)]) else $error("unit not stored");
	a_end_stops: assert property (assign_run && disc_end |=> !assign_run)
		else $error("collection did not stop");
	a_words_hold: assert property (!assign_run && !(psel && penable && pwrite)
		|=> $stable(stn_active)) else $error("words changed without cause");
	a_misaligned_err: assert property (psel && penable && paddr[1:0] != 2'h0
		|-> pslverr) else $error("misaligned access accepted");
	// main scenarios reached
	c_collect_end: cover property (assign_run && disc_end);
	c_test_mode: cover property (cnt_r == 7'h73 && mode_test);
	c_refused: cover property (psel && penable && pslverr);
endmodule : fmss_top_sva
bind fmss_top fmss_top_sva fmss_top_sva_i (.*);

// ---- tb/test_fmss_top.sv ----
// Purpose: self-checking bench of the setup and supervision block
// Assumes: apb answer may take any number of cycles up to a bound
// Notes:   switches are read once per power-up, so each decode needs a reset
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module test_fmss_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0]  sw_pin = 8'h00;
	logic [63:0] drop = 64'h0, stn_present, stn_active;
	logic [5:0]  disc_stn;
	logic [4:0]  disc_npts;
	logic [1:0]  rate_code;
	logic        pready, pslverr, er, disc_valid, disc_in, disc_out, disc_first, disc_end;
	logic        assign_run, point_mode_select, mode_online, mode_assign, mode_test, irq;
	logic [31:0] exp_w [5] = '{32'h0904, 32'h0b02, 32'h0302, 32'h0a04, 32'h0};
	int          errors = 0, n_checks = 0;
	fmss_top fmss_top_i (.*);
	fmss_stations fmss_stations_i (.*);
	always #5 pclk = ~pclk;
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	// one apb transfer; request held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin errors++; complete_run; end
		@(posedge pclk);
	endtask : apb
	task automatic wait_done;
		int i;
		for (i = 0; i < 200 && assign_run !== 1'b0; i++) @(posedge pclk);
		if (i >= 200) begin errors++; complete_run; end
	endtask : wait_done
	// reset with switches s, check the decode, then move a switch
	task automatic power_up(input logic [7:0] s);
		presetn <= 1'b0;
		sw_pin <= s;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (118) @(posedge pclk);
		`CHK("rate", {s[1], s[0]}, rate_code)
		`CHK("points", s[2], point_mode_select)
		`CHK("assign", s[5] & ~s[6], mode_assign)
		`CHK("test", s[6] & ~s[5], mode_test)
		`CHK("online", ~s[5] & ~s[6], mode_online)
		apb(1'b0, 12'h060, 32'h0);
		`CHK("cfg", s, rd[7:0])
		sw_pin <= s ^ 8'h04;
		repeat (10) @(posedge pclk);
		`CHK("held", s[2], point_mode_select)
	endtask : power_up
	initial begin
		power_up(8'h05);
		power_up(8'h42);
		power_up(8'h00);
		// online: reserved station 1 and plain station 2, then both unplugged
		apb(1'b1, 12'h080, 32'h8904);
		apb(1'b1, 12'h084, 32'h0b02);
		`CHK("rsv active", 1'b1, stn_active[0])
		drop <= 64'h3;
		repeat (4) @(posedge pclk);
		apb(1'b0, 12'h078, 32'h0);
		`CHK("faults", 32'h2, rd)
		drop <= 64'h0;
		apb(1'b0, 12'h200, 32'h0);
		`CHK("unmapped", 1'b1, er)
		apb(1'b0, 12'h081, 32'h0);
		`CHK("misaligned", 1'b1, er)
		`CHK("refused rd", 32'h0, rd)
		apb(1'b1, 12'h085, 32'hffff);
		apb(1'b0, 12'h084, 32'h0);
		`CHK("refused wr", 32'h0b02, rd)
		power_up(8'h20);
		wait_done;
		apb(1'b0, 12'h070, 32'h0);
		`CHK("done", 1'b1, rd[4])
		for (int n = 0; n < 5; n++) begin
			apb(1'b0, 12'h080 + 12'(4 * n), 32'h0);
			`CHK("word", exp_w[n], rd)
		end
		// done event: masked, unmasked, cleared
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, 12'h068, 32'h1);
		`CHK("irq raised", 1'b1, irq)
		apb(1'b1, 12'h064, 32'h1);
		`CHK("irq cleared", 1'b0, irq)
		// rerun rewrites a station marked reserved by software
		apb(1'b1, 12'h080, 32'h8904);
		apb(1'b1, 12'h074, 32'h1);
		apb(1'b0, 12'h074, 32'h0);
		`CHK("rerun busy", 1'b1, rd[0])
		wait_done;
		apb(1'b0, 12'h080, 32'h0);
		`CHK("rerun word", 32'h0904, rd)
		complete_run;
	end
endmodule : test_fmss_top
